// ---- hdl/cmg_access_guard.sv ----
// Mode access guard: grants or refuses each mode-tagged CPU access.
//
// Function
// - Boot and test modes exercise the whole device, but may only read the segmentation registers.
// - Contactless mode is confined by the fixed memory partition.
// - Only small shared area is exchanged; system mode controls its opening.
// - System mode writes segmentation registers and may move the table base.
// - User mode has no access to segmentation registers.
// - User mode may write table contents in a segment it may write.
// - Reset clears the table base to zero, disabling all segments.
// - Memory partition is fixed in hardware with no reconfiguration path.
// - No requester can replace the restrictive reset values.
// - User hardware register access follows the executing segment's rights.
// - Segmentation register writes are refused outside system mode.
`include "cmg_cfg.svh"
`default_nettype none
module cmg_access_guard #(
   parameter int ADDR_W = 16
) (
   // Clock and reset.
   input  wire logic             i_clk,
   input  wire logic             i_rstn,
   // Access from the CPU core.
   input  wire logic             i_acc_valid,
   input  wire cmg_pkg::cmg_mode_t i_acc_mode,
   input  wire logic             i_acc_sfr,
   input  wire logic             i_acc_wr,
   input  wire logic [ADDR_W-1:0] i_acc_addr,
   input  wire logic [7:0]       i_acc_wdata,
   // Rights of the executing segment and the contactless firewall.
   input  wire logic             i_seg_rd_ok,
   input  wire logic             i_seg_wr_ok,
   input  wire logic             i_seg_sfr_ok,
   input  wire logic             i_fw_sfr_ok,
   // Verdict.
   output logic                  o_grant,
   output logic                  o_deny,
   output logic                  o_hw_sfr_we,
   output logic                  o_mem_we,
   // Segmentation state.
   output logic [7:0]            o_seg_rdata,
   output logic [15:0]           o_seg_base,
   output logic                  o_segs_enabled,
   output logic                  o_xchg_open
);

   // Elaboration check: the partition constants need a 16-bit address.
   if (ADDR_W != 16) begin : g_addr_check
      $error("cmg_access_guard supports ADDR_W of 16 only.");
   end

   logic m_boot;
   logic m_test;
   logic m_cl;
   logic m_sys;
   logic m_user;
   logic m_priv;
   logic [7:0] sfr_adr;
   logic is_seg_sfr;
   logic is_hw_sfr;
   logic in_cl_part;
   logic in_xchg;
   logic sfr_ok;
   logic mem_ok;
   logic seg_we;
   logic seg_re;
   logic xchg_open;

   // Mode decode.
   // An illegal mode code matches none of these decodes and so earns no rights at all.
   assign m_boot = (i_acc_mode == cmg_pkg::CMG_MODE_BOOT);
   assign m_test = (i_acc_mode == cmg_pkg::CMG_MODE_TEST);
   assign m_cl   = (i_acc_mode == cmg_pkg::CMG_MODE_CL);
   assign m_sys  = (i_acc_mode == cmg_pkg::CMG_MODE_SYS);
   assign m_user = (i_acc_mode == cmg_pkg::CMG_MODE_USER);
   assign m_priv = m_boot || m_test;

   // Special register class decode.
   assign sfr_adr    = i_acc_addr[7:0];
   assign is_seg_sfr = (sfr_adr == `CMG_SEG_BASE_LO_ADR) ||
                       (sfr_adr == `CMG_SEG_BASE_HI_ADR) ||
                       (sfr_adr == `CMG_XCHG_CTRL_ADR);
   assign is_hw_sfr  = (sfr_adr >= `CMG_HW_SFR_LO_ADR);

   // Partition decode from constants only; no register can move it.
   // Moving the partition would need a register, so its bounds are constants by design.
   assign in_cl_part = (i_acc_addr >= `CMG_CL_PART_LO) && (i_acc_addr <= `CMG_CL_PART_HI);
   assign in_xchg    = (i_acc_addr >= `CMG_XCHG_LO) && (i_acc_addr <= `CMG_XCHG_HI);

   // Special register verdict by mode and class.
   // Boot and test may read the segmentation registers; writing them is left to system mode.
   assign sfr_ok = is_seg_sfr ? (m_sys || (m_priv && !i_acc_wr)) :
                   !is_hw_sfr ? (m_priv || m_sys) :
                   (m_priv || m_sys ||
                    (m_user && i_seg_sfr_ok) ||
                    (m_cl && i_fw_sfr_ok));

   // Memory verdict by mode and partition.
   // Segment rights never open the contactless partition to system or user code.
   assign mem_ok = m_priv || m_sys && !in_cl_part ||
                   m_cl && (in_cl_part || (in_xchg && (!i_acc_wr || xchg_open))) ||
                   m_user && !in_cl_part &&
                   (i_acc_wr ? i_seg_wr_ok : i_seg_rd_ok);

   // Verdict for the access presented in this cycle.
   assign o_grant = i_acc_valid && (i_acc_sfr ? sfr_ok : mem_ok);
   assign o_deny  = i_acc_valid && !o_grant;

   // Write strobes reach a target only when granted.
   // Gating every strobe by the grant keeps a refused write from touching any target.
   assign seg_we      = o_grant && i_acc_sfr && i_acc_wr && is_seg_sfr;
   assign seg_re      = o_grant && i_acc_sfr && !i_acc_wr && is_seg_sfr;
   assign o_hw_sfr_we = o_grant && i_acc_sfr && i_acc_wr && !is_seg_sfr;
   assign o_mem_we    = o_grant && !i_acc_sfr && i_acc_wr;

   // Segmentation registers.
   cmg_seg_regs u_regs (
      .i_clk       (i_clk),
      .i_rstn      (i_rstn),
      .i_we        (seg_we),
      .i_waddr     (sfr_adr),
      .i_wdata     (i_acc_wdata),
      .i_re        (seg_re),
      .i_raddr     (sfr_adr),
      .o_seg_base  (o_seg_base),
      .o_xchg_open (xchg_open),
      .o_rdata     (o_seg_rdata)
   );

   // A zero base leaves every segment disabled.
   // Fetch logic must treat a disabled table as holding no executable user segment.
   assign o_segs_enabled = (o_seg_base != 16'h0000);
   assign o_xchg_open    = xchg_open;

   // Assertions.
   user_seg_deny_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_acc_valid && m_user && i_acc_sfr && is_seg_sfr |-> o_deny)
      else $error("User reached a segmentation register.");

   seg_wr_sys_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_acc_valid && !m_sys && i_acc_sfr && i_acc_wr && is_seg_sfr |-> o_deny ##1 $stable(o_seg_base))
      else $error("Segmentation write taken outside system mode.");

   sys_base_move_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_acc_valid && m_sys && i_acc_sfr && i_acc_wr && sfr_adr == `CMG_SEG_BASE_LO_ADR
      |=> o_seg_base[7:0] == $past(i_acc_wdata))
      else $error("System mode could not move the table base.");

   priv_grant_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_acc_valid && m_priv && !(i_acc_sfr && i_acc_wr && is_seg_sfr) |-> o_grant)
      else $error("Boot or test access refused.");

   cl_part_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_acc_valid && !i_acc_sfr && (m_sys || m_user) && in_cl_part |-> o_deny)
      else $error("Contactless partition reached from outside.");

   cl_confine_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_acc_valid && !i_acc_sfr && m_cl && !in_cl_part && !in_xchg |-> o_deny)
      else $error("Contactless mode left its partition.");

   xchg_closed_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_acc_valid && !i_acc_sfr && m_cl && in_xchg && i_acc_wr && !o_xchg_open |-> !o_mem_we)
      else $error("Exchange area written while closed.");

   user_table_wr_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_acc_valid && !i_acc_sfr && m_user && i_acc_wr && !in_cl_part && i_seg_wr_ok
      |-> o_mem_we)
      else $error("Write-permitted user write refused.");

   user_hw_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_acc_valid && m_user && i_acc_sfr && is_hw_sfr |-> o_grant == i_seg_sfr_ok)
      else $error("User hardware register access ignores segment rights.");

   deny_no_we_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      o_deny |-> !o_hw_sfr_we && !o_mem_we ##1 $stable(o_seg_base))
      else $error("Denied write reached a target.");

   reset_base_a: assert property (@(posedge i_clk)
      $rose(i_rstn) |-> o_seg_base == `CMG_SEG_BASE_RST && !o_segs_enabled)
      else $error("Table base not cleared by reset.");

   // Contactless isolation, exchange control, table base high-byte move and register read-back.
   cl_seg_deny_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_acc_valid && m_cl && i_acc_sfr && is_seg_sfr |-> o_deny)
      else $error("Contactless mode reached a segmentation register.");

   cl_hw_fw_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_acc_valid && m_cl && i_acc_sfr && is_hw_sfr |-> o_grant == i_fw_sfr_ok)
      else $error("Contactless hardware register access ignores the firewall.");

   xchg_ctrl_sys_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_acc_valid && !m_sys && i_acc_sfr && i_acc_wr && sfr_adr == `CMG_XCHG_CTRL_ADR
      |=> $stable(o_xchg_open))
      else $error("Exchange area control changed outside system mode.");

   sys_hi_move_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_acc_valid && m_sys && i_acc_sfr && i_acc_wr && sfr_adr == `CMG_SEG_BASE_HI_ADR
      |=> o_seg_base[15:8] == $past(i_acc_wdata))
      else $error("System mode could not move the table base high byte.");

   seg_rd_lo_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      seg_re && sfr_adr == `CMG_SEG_BASE_LO_ADR |=> o_seg_rdata == $past(o_seg_base[7:0]))
      else $error("Table base low byte read back wrong.");

   seg_rd_hi_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      seg_re && sfr_adr == `CMG_SEG_BASE_HI_ADR |=> o_seg_rdata == $past(o_seg_base[15:8]))
      else $error("Table base high byte read back wrong.");

   reset_xchg_a: assert property (@(posedge i_clk)
      $rose(i_rstn) |-> o_xchg_open == `CMG_XCHG_OPEN_RST)
      else $error("Exchange area not closed by reset.");

   // Main scenarios.
   sys_move_c: cover property (@(posedge i_clk) disable iff (!i_rstn) seg_we && m_sys);
   user_deny_c: cover property (@(posedge i_clk) disable iff (!i_rstn) o_deny && m_user);
   cl_xchg_c: cover property (@(posedge i_clk) disable iff (!i_rstn)
      o_mem_we && m_cl && in_xchg);
   priv_cfg_c: cover property (@(posedge i_clk) disable iff (!i_rstn)
      o_grant && m_priv && i_acc_sfr);
   user_hw_c: cover property (@(posedge i_clk) disable iff (!i_rstn)
      o_hw_sfr_we && m_user);

endmodule : cmg_access_guard
`default_nettype wire

// ---- hdl/cmg_cfg.svh ----
// Fixed address map, field positions and reset values of the mode access guard.
`ifndef CMG_CFG_SVH
`define CMG_CFG_SVH

// Special register addresses that configure the segmentation.
`define CMG_SEG_BASE_LO_ADR 8'hA0
`define CMG_SEG_BASE_HI_ADR 8'hA1
`define CMG_XCHG_CTRL_ADR   8'hA2

// Lowest special register address that belongs to hardware components.
`define CMG_HW_SFR_LO_ADR   8'hC0

// Field position of the exchange area open bit in the exchange control register.
`define CMG_XCHG_OPEN_BIT   0

// Restrictive reset values: a zero table base disables every segment.
`define CMG_SEG_BASE_RST    16'h0000
`define CMG_XCHG_OPEN_RST   1'h0

// Fixed memory partition of the contactless operating system and the shared area.
`define CMG_CL_PART_LO      16'hC000
`define CMG_CL_PART_HI      16'hDFFF
`define CMG_XCHG_LO         16'hE000
`define CMG_XCHG_HI         16'hE0FF

`endif

// ---- hdl/cmg_pkg.sv ----
// Types shared by the mode access guard files.
`default_nettype none
package cmg_pkg;

   // CPU privilege mode presented with every access, one-hot.
   typedef enum logic [4:0] {
      CMG_MODE_BOOT = 5'h01,
      CMG_MODE_TEST = 5'h02,
      CMG_MODE_CL   = 5'h04,
      CMG_MODE_SYS  = 5'h08,
      CMG_MODE_USER = 5'h10
   } cmg_mode_t;

endpackage : cmg_pkg
`default_nettype wire

// ---- hdl/cmg_seg_regs.sv ----
// Segmentation configuration registers: segment table base and exchange area control.
`include "cmg_cfg.svh"
`default_nettype none
module cmg_seg_regs (
   // Clock and reset.
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   // Gated write port.
   input  wire logic        i_we,
   input  wire logic [7:0]  i_waddr,
   input  wire logic [7:0]  i_wdata,
   // Gated read port.
   input  wire logic        i_re,
   input  wire logic [7:0]  i_raddr,
   // Register contents.
   output logic      [15:0] o_seg_base,
   output logic             o_xchg_open,
   output logic      [7:0]  o_rdata
);

   logic [15:0] base_q;
   logic        xchg_q;
   logic [7:0]  rdata_q;
   logic [7:0]  rdata_d;
   logic        wr_lo;
   logic        wr_hi;
   logic        wr_xc;

   // Write decode; the set of registers is fixed, nothing else can be created.
   assign wr_lo = i_we && (i_waddr == `CMG_SEG_BASE_LO_ADR);
   assign wr_hi = i_we && (i_waddr == `CMG_SEG_BASE_HI_ADR);
   assign wr_xc = i_we && (i_waddr == `CMG_XCHG_CTRL_ADR);

   // Read selection; unmapped addresses read as zero.
   assign rdata_d = (i_raddr == `CMG_SEG_BASE_LO_ADR) ? base_q[7:0]  :
                    (i_raddr == `CMG_SEG_BASE_HI_ADR) ? base_q[15:8] :
                    (i_raddr == `CMG_XCHG_CTRL_ADR)   ? {7'h00, xchg_q} : 8'h00;

   // Registers reset only to their fixed restrictive values.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         base_q  <= `CMG_SEG_BASE_RST;
         xchg_q  <= `CMG_XCHG_OPEN_RST;
         rdata_q <= 8'h00;
      end else begin
         if (wr_lo) base_q[7:0]  <= i_wdata;
         if (wr_hi) base_q[15:8] <= i_wdata;
         if (wr_xc) xchg_q       <= i_wdata[`CMG_XCHG_OPEN_BIT];
         if (i_re)  rdata_q      <= rdata_d;
      end
   end

   assign o_seg_base  = base_q;
   assign o_xchg_open = xchg_q;
   assign o_rdata     = rdata_q;

   // Base register holds whenever no write is steered to it.
   base_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !wr_lo && !wr_hi |=> $stable(base_q)) else $error("Base changed without write.");

endmodule : cmg_seg_regs
`default_nettype wire

// ---- sim/cmg_cpu_model.sv ----
// CPU core model that presents mode-tagged accesses and segment rights to the guard.
`default_nettype none
module cmg_cpu_model (
   // Clock.
   input  wire logic          i_clk,
   // Access toward the guard.
   output cmg_pkg::cmg_mode_t o_mode,
   output logic               o_valid,
   output logic               o_sfr,
   output logic               o_wr,
   output logic [15:0]        o_addr,
   output logic [7:0]         o_wdata,
   // Rights of the executing segment and the firewall.
   output logic               o_rd_ok,
   output logic               o_wr_ok,
   output logic               o_sfr_ok,
   output logic               o_fw_ok
);
   timeunit 1ns;
   timeprecision 1ps;

   // Bus starts idle with no rights granted.
   initial begin
      o_mode = cmg_pkg::CMG_MODE_SYS;
      {o_valid, o_sfr, o_wr, o_addr, o_wdata} = '0;
      {o_rd_ok, o_wr_ok, o_sfr_ok, o_fw_ok} = 4'h0;
   end

   // One access per cycle, changed after the falling edge, carrying its own mode.
   task automatic issue(input cmg_pkg::cmg_mode_t mode, input logic sfr, input logic wr,
                        input logic [15:0] addr, input logic [7:0] wdata);
      @(negedge i_clk);
      o_valid = 1'b1;
      o_mode  = mode;
      o_sfr   = sfr;
      o_wr    = wr;
      o_addr  = addr;
      o_wdata = wdata;
   endtask : issue

   // A released bus shows the inverse of its last address and data, not a stale copy.
   task automatic idle();
      @(negedge i_clk);
      o_valid = 1'b0;
      o_addr  = ~o_addr;
      o_wdata = ~o_wdata;
   endtask : idle

   // Rights of the segment that the current code executes from.
   task automatic rights(input logic [3:0] r);
      {o_rd_ok, o_wr_ok, o_sfr_ok, o_fw_ok} = r;
   endtask : rights
endmodule : cmg_cpu_model
`default_nettype wire

// ---- sim/test_cpu_mode_mmu_access_guard.sv ----
// Self-checking testbench of the mode access guard.
`default_nettype none
module test_cpu_mode_mmu_access_guard;
   timeunit 1ns;
   timeprecision 1ps;

   logic i_clk, i_rstn, valid, sfr, wr, rd_ok, wr_ok, sfr_ok, fw_ok;
   logic o_grant, o_deny, o_hw_sfr_we, o_mem_we, o_segs_enabled, o_xchg_open;
   logic [15:0] addr, o_seg_base;
   logic [7:0]  wdata, o_seg_rdata;
   cmg_pkg::cmg_mode_t mode;
   int fail_count, checked;

   cmg_cpu_model cpu (.i_clk(i_clk), .o_mode(mode), .o_valid(valid), .o_sfr(sfr), .o_wr(wr),
      .o_addr(addr), .o_wdata(wdata), .o_rd_ok(rd_ok), .o_wr_ok(wr_ok), .o_sfr_ok(sfr_ok),
      .o_fw_ok(fw_ok));
   cmg_access_guard uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_acc_valid(valid),
      .i_acc_mode(mode), .i_acc_sfr(sfr), .i_acc_wr(wr), .i_acc_addr(addr),
      .i_acc_wdata(wdata), .i_seg_rd_ok(rd_ok), .i_seg_wr_ok(wr_ok), .i_seg_sfr_ok(sfr_ok),
      .i_fw_sfr_ok(fw_ok), .o_grant(o_grant), .o_deny(o_deny), .o_hw_sfr_we(o_hw_sfr_we),
      .o_mem_we(o_mem_we), .o_seg_rdata(o_seg_rdata), .o_seg_base(o_seg_base),
      .o_segs_enabled(o_segs_enabled), .o_xchg_open(o_xchg_open));

   // Clock of 8 ns and a reset held for four cycles.
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   // Counts one comparison and reports a mismatch at once.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   // Presents one access and judges the same-cycle verdict and strobes.
   task automatic acc(input cmg_pkg::cmg_mode_t m, input logic s, input logic w,
                      input logic [15:0] a, input logic [7:0] d, input logic g);
      cpu.issue(m, s, w, a, d);
      #1;
      check(16'(o_grant), 16'(g));
      check(16'(o_deny), 16'(!g));
      check(16'(o_mem_we), 16'(g & w & !s));
      if (s && (a[7:0] < 8'hA0 || a[7:0] > 8'hA2)) check(16'(o_hw_sfr_we), 16'(g & w));
   endtask : acc

   // Ends the access and lets the last edge land in the registers.
   task automatic settle();
      cpu.idle();
      #1;
   endtask : settle

   task automatic t_reset();
      check(o_seg_base, 16'h0000);
      check(16'(o_segs_enabled), 16'h0000);
      check(16'(o_xchg_open), 16'h0000);
   endtask : t_reset

   task automatic t_sys_cfg();
      acc(cmg_pkg::CMG_MODE_SYS, 1'b1, 1'b1, 16'h00A0, 8'h55, 1'b1);
      acc(cmg_pkg::CMG_MODE_SYS, 1'b1, 1'b1, 16'h00A1, 8'h12, 1'b1);
      acc(cmg_pkg::CMG_MODE_SYS, 1'b1, 1'b0, 16'h00A0, 8'h00, 1'b1);
      settle();
      check(o_seg_base, 16'h1255);
      check(16'(o_segs_enabled), 16'h0001);
      check(16'(o_seg_rdata), 16'h0055);
   endtask : t_sys_cfg

   task automatic t_deny_cfg();
      cmg_pkg::cmg_mode_t ml[4];
      ml = '{cmg_pkg::CMG_MODE_BOOT, cmg_pkg::CMG_MODE_TEST, cmg_pkg::CMG_MODE_CL,
             cmg_pkg::CMG_MODE_USER};
      foreach (ml[i]) acc(ml[i], 1'b1, 1'b1, 16'h00A0, 8'hFF, 1'b0);
      acc(cmg_pkg::CMG_MODE_BOOT, 1'b1, 1'b0, 16'h00A1, 8'h00, 1'b1);
      acc(cmg_pkg::CMG_MODE_USER, 1'b1, 1'b0, 16'h00A0, 8'h00, 1'b0);
      acc(cmg_pkg::CMG_MODE_TEST, 1'b0, 1'b1, 16'hC100, 8'h3C, 1'b1);
      settle();
      check(o_seg_base, 16'h1255);
      check(16'(o_seg_rdata), 16'h0012);
   endtask : t_deny_cfg

   task automatic t_user_mem();
      cpu.rights(4'hC);
      acc(cmg_pkg::CMG_MODE_USER, 1'b0, 1'b1, 16'h0200, 8'hAA, 1'b1);
      acc(cmg_pkg::CMG_MODE_USER, 1'b0, 1'b0, 16'hC100, 8'h00, 1'b0);
      acc(cmg_pkg::CMG_MODE_SYS, 1'b0, 1'b0, 16'hC100, 8'h00, 1'b0);
      cpu.rights(4'h8);
      acc(cmg_pkg::CMG_MODE_USER, 1'b0, 1'b1, 16'h0200, 8'hAA, 1'b0);
   endtask : t_user_mem

   task automatic t_cl_xchg();
      acc(cmg_pkg::CMG_MODE_CL, 1'b0, 1'b0, 16'hC100, 8'h00, 1'b1);
      acc(cmg_pkg::CMG_MODE_CL, 1'b0, 1'b0, 16'h0200, 8'h00, 1'b0);
      acc(cmg_pkg::CMG_MODE_CL, 1'b0, 1'b1, 16'hE010, 8'h5A, 1'b0);
      acc(cmg_pkg::CMG_MODE_CL, 1'b0, 1'b0, 16'hE010, 8'h00, 1'b1);
      acc(cmg_pkg::CMG_MODE_SYS, 1'b1, 1'b1, 16'h00A2, 8'h01, 1'b1);
      acc(cmg_pkg::CMG_MODE_CL, 1'b0, 1'b1, 16'hE010, 8'h5A, 1'b1);
      acc(cmg_pkg::CMG_MODE_USER, 1'b1, 1'b1, 16'h00A2, 8'h00, 1'b0);
      settle();
      check(16'(o_xchg_open), 16'h0001);
   endtask : t_cl_xchg

   task automatic t_hw_sfr();
      cpu.rights(4'h0);
      acc(cmg_pkg::CMG_MODE_USER, 1'b1, 1'b1, 16'h00C5, 8'h11, 1'b0);
      acc(cmg_pkg::CMG_MODE_CL, 1'b1, 1'b1, 16'h00C5, 8'h11, 1'b0);
      cpu.rights(4'h3);
      acc(cmg_pkg::CMG_MODE_USER, 1'b1, 1'b1, 16'h00C5, 8'h11, 1'b1);
      acc(cmg_pkg::CMG_MODE_CL, 1'b1, 1'b1, 16'h00C5, 8'h11, 1'b1);
      acc(cmg_pkg::CMG_MODE_USER, 1'b1, 1'b1, 16'h0010, 8'h11, 1'b0);
      acc(cmg_pkg::CMG_MODE_SYS, 1'b1, 1'b1, 16'h0010, 8'h11, 1'b1);
      settle();
   endtask : t_hw_sfr

   // A second reset in mid-run brings back the restrictive values at once.
   task automatic t_rereset();
      @(negedge i_clk);
      i_rstn = 1'b0;
      #1;
      t_reset();
      check(o_seg_base, 16'h0000);
      @(negedge i_clk);
      i_rstn = 1'b1;
      acc(cmg_pkg::CMG_MODE_SYS, 1'b1, 1'b1, 16'h00A0, 8'h33, 1'b1);
      acc(cmg_pkg::CMG_MODE_SYS, 1'b1, 1'b0, 16'h00A1, 8'h00, 1'b1);
      settle();
      check(o_seg_base, 16'h0033);
      check(16'(o_seg_rdata), 16'h0000);
   endtask : t_rereset

   task automatic close_out();
      $display("Counts: %0d mismatches in %0d comparisons", fail_count, checked);
      if (fail_count == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out

   // Main sequence.
   initial begin
      fail_count = 0;
      checked = 0;
      i_rstn = 1'b0;
      repeat (4) @(negedge i_clk);
      i_rstn = 1'b1;
      t_reset();
      t_sys_cfg();
      t_deny_cfg();
      t_user_mem();
      t_cl_xchg();
      t_hw_sfr();
      t_rereset();
      close_out();
   end

   // Watchdog well beyond the roughly 40 cycles that the tests need.
   initial begin
      #20us;
      fail_count++;
      close_out();
   end
endmodule : test_cpu_mode_mmu_access_guard
`default_nettype wire
